// ===== pkg/vip_map.vh
`ifndef VIP_MAP_VH
`define VIP_MAP_VH
// Register byte offsets (low address byte)
`define VIP_CTRL_OFS 8'h00
`define VIP_STAT_OFS 8'h04
`define VIP_PTMR_OFS 8'h08
`define VIP_VBASE_OFS 8'h0c
`define VIP_VSPACE_OFS 8'h10
`define VIP_FLAG0_OFS 8'h20
`define VIP_FLAG1_OFS 8'h24
`define VIP_EN0_OFS 8'h30
`define VIP_EN1_OFS 8'h34
`define VIP_PRIO0_OFS 8'h40
`define VIP_PRIO_WORDS 11
// Control word fields
`define VIP_MULTI_VECTOR_SELECT_BIT 12
`define VIP_TPC_MSB 10
`define VIP_TPC_LSB 8
`define VIP_EDGE_MSB 4
`define VIP_EDGE_LSB 0
// Status word fields
`define VIP_SLVL_MSB 10
`define VIP_SLVL_LSB 8
`define VIP_SVEC_MSB 5
`define VIP_SVEC_LSB 0
// Priority byte fields
`define VIP_PRI_MSB 4
`define VIP_PRI_LSB 2
`define VIP_SUB_MSB 1
`define VIP_SUB_LSB 0
// Reset values
`define VIP_CTRL_RST 32'h0000_0000
`define VIP_WORD_RST 32'h0000_0000
`define VIP_PTMR_RST 32'h0000_0000
// Source classes
`define VIP_PERSIST_MASK 64'h0fff_fff8_1631_8c60
`define VIP_EXT0_IRQ 3
`define VIP_EXT1_IRQ 8
`define VIP_EXT2_IRQ 13
`define VIP_EXT3_IRQ 18
`define VIP_EXT4_IRQ 23
`endif

// ===== logic/vip_edge.v
`timescale 1ns/100ps
module vip_edge #(
  parameter N = 5
) (
  input wire clk_i,
  input wire rst_i,
  input wire [N-1:0] line_i,
  input wire [N-1:0] rise_sel_i,
  output wire [N-1:0] pulse_o
);
  reg [N-1:0] sync_a;
  reg [N-1:0] sync_b;
  reg [N-1:0] prev;

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= {N{1'b0}};
      sync_b <= {N{1'b0}};
      prev <= {N{1'b0}};
    end else begin
      sync_a <= line_i;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  // Select 1 picks the rising edge, 0 the falling one
  assign pulse_o = (rise_sel_i & sync_b & ~prev) | (~rise_sel_i & ~sync_b & prev);
endmodule

// ===== logic/vip_arb.v
`timescale 1ns/100ps
`include "vip_map.vh"
module vip_arb #(
  parameter NSRC = 64,
  parameter NVEC = 44
) (
  input wire [NSRC-1:0] flag_i,
  input wire [NSRC-1:0] en_i,
  input wire [NVEC*8-1:0] prio_i,
  output reg win_o,
  output reg [5:0] win_irq_o,
  output reg [5:0] win_vec_o,
  output reg [2:0] win_pri_o,
  output reg [1:0] win_sub_o
);
  // Several sources share a vector and its priority byte
  function [5:0] vec_of;
    input [5:0] irq;
    begin
      if (irq <= 6'd5) vec_of = irq;
      else if (irq == 6'd6) vec_of = 6'd5;
      else if (irq <= 6'd10) vec_of = irq - 6'd1;
      else if (irq == 6'd11) vec_of = 6'd9;
      else if (irq <= 6'd15) vec_of = irq - 6'd2;
      else if (irq == 6'd16) vec_of = 6'd13;
      else if (irq <= 6'd20) vec_of = irq - 6'd3;
      else if (irq <= 6'd25) vec_of = irq - 6'd4;
      else if (irq <= 6'd36) vec_of = irq - 6'd5;
      else if (irq <= 6'd38) vec_of = 6'd31;
      else if (irq <= 6'd41) vec_of = 6'd32;
      else if (irq <= 6'd44) vec_of = 6'd33;
      else if (irq <= 6'd47) vec_of = 6'd34;
      else if (irq <= 6'd49) vec_of = 6'd35;
      else if (irq <= 6'd52) vec_of = 6'd36;
      else if (irq <= 6'd55) vec_of = 6'd37;
      else if (irq <= 6'd58) vec_of = 6'd38;
      else vec_of = irq - 6'd20;
    end
  endfunction

  integer i;
  reg [5:0] v;
  reg [7:0] pb;
  always @* begin
    win_o = 1'b0;
    win_irq_o = 6'h00;
    win_vec_o = 6'h00;
    win_pri_o = 3'h0;
    win_sub_o = 2'h0;
    v = 6'h00;
    pb = 8'h00;
    for (i = 0; i < NSRC; i = i + 1) begin
      v = vec_of(i[5:0]);
      pb = prio_i[v*8 +: 8];
      // Competes only when flagged, enabled and at nonzero priority
      if (flag_i[i] && en_i[i] && (pb[`VIP_PRI_MSB:`VIP_PRI_LSB] != 3'h0)) begin
        // Strictly greater wins, so on ties the lower IRQ stays
        if (!win_o || {pb[`VIP_PRI_MSB:`VIP_PRI_LSB], pb[`VIP_SUB_MSB:`VIP_SUB_LSB]} > {win_pri_o, win_sub_o}) begin
          win_o = 1'b1;
          win_irq_o = i[5:0];
          win_vec_o = v;
          win_pri_o = pb[`VIP_PRI_MSB:`VIP_PRI_LSB];
          win_sub_o = pb[`VIP_SUB_MSB:`VIP_SUB_LSB];
        end
      end
    end
  end
endmodule

// ===== logic/vip_top.v
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`include "vip_map.vh"
// Summary of operation
// - Separate unit arbitrates pending requests, forwards only the winner and vector.
// - Sixty-four sources 0..63 mapped onto forty-four vectors 0..43.
// - Single-vector scheme uses one common vector; multi-vector delivers each vector.
// - Five external inputs, each with selectable active edge raising its flag.
// - Per vector 3-bit priority and 2-bit subpriority; vector 0 at bits 4:2, 1:0.
// - Software writing a pending flag raises the interrupt like hardware.
// - Vector table base and entry spacing are programmable.
// - Proximity timer defers selected requests to group closely spaced interrupts.
// - No dedicated alternate register set for interrupt service.
// - Equal priority and subpriority: lower IRQ number wins.
// - Flag and enable of IRQ n sit at bit n mod 32 of word n/32.
// - Capture error and capture event requests share one vector and priority.
// - Serial, two-wire and change-notice groups share one vector and priority.
// - Converter and communication sources persistent; timers, DMA and external are not.
// - All USB events merge into IRQ 35, vector 30, persistent.
// - Four DMA channels own IRQs 60..63 on vectors 40..43.
// - Software interrupts are IRQs 1 and 2, each on its own vector.
// - Vectoring select bit: 1 multi-vector, 0 single-vector.
// - Proximity field: group priority at or below value starts timer; zero disables.
// - Edge select 1 picks rising edge, 0 falling edge.
// - Status reports priority and 6-bit vector of latest presented request.
module vip_top #(
  parameter NSRC = 64,
  parameter NVEC = 44,
  parameter NEXT = 5
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [NSRC-1:0] periph_req_i,
  input wire [NEXT-1:0] ext_line_i,
  output reg cpu_req_o,
  output reg [5:0] cpu_vector_o,
  output reg [2:0] cpu_level_o,
  output reg [31:0] cpu_vec_addr_o
);
  ////////////////////////////////////////////////////////////////////////////
  reg [31:0] ctrl;
  reg [31:0] ptmr;
  reg [31:0] vbase;
  reg [31:0] vspace;
  reg [NSRC-1:0] flag;
  reg [NSRC-1:0] en;
  reg [31:0] prio [0:`VIP_PRIO_WORDS-1];
  reg [2:0] stat_lvl;
  reg [5:0] stat_vec;
  reg [NSRC-1:0] req_prev;
  reg [31:0] tmr;
  reg tmr_run;
  reg tmr_done;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    reg [31:0] m;
    begin
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  // Address decoded once, shared by the write and the read path
  localparam [3:0] R_CTRL = 4'h0;
  localparam [3:0] R_STAT = 4'h1;
  localparam [3:0] R_PTMR = 4'h2;
  localparam [3:0] R_VBASE = 4'h3;
  localparam [3:0] R_VSPACE = 4'h4;
  localparam [3:0] R_FLAG0 = 4'h5;
  localparam [3:0] R_FLAG1 = 4'h6;
  localparam [3:0] R_EN0 = 4'h7;
  localparam [3:0] R_EN1 = 4'h8;
  localparam [3:0] R_PRIO = 4'h9;
  localparam [3:0] R_NONE = 4'hf;

  function [3:0] reg_of;
    input [7:0] a;
    begin
      case (a)
        `VIP_CTRL_OFS: reg_of = R_CTRL;
        `VIP_STAT_OFS: reg_of = R_STAT;
        `VIP_PTMR_OFS: reg_of = R_PTMR;
        `VIP_VBASE_OFS: reg_of = R_VBASE;
        `VIP_VSPACE_OFS: reg_of = R_VSPACE;
        `VIP_FLAG0_OFS: reg_of = R_FLAG0;
        `VIP_FLAG1_OFS: reg_of = R_FLAG1;
        `VIP_EN0_OFS: reg_of = R_EN0;
        `VIP_EN1_OFS: reg_of = R_EN1;
        default: begin
          if ((a >= `VIP_PRIO0_OFS) && (a < `VIP_PRIO0_OFS + 8'd4 * `VIP_PRIO_WORDS)) begin
            reg_of = R_PRIO;
          end else begin
            reg_of = R_NONE;
          end
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: ack one cycle after request, write at the acked edge
  wire req = wb_cyc_i & wb_stb_i;
  wire wr_en = req & wb_we_i & wb_ack_o;
  wire [7:0] adr = {wb_adr_i[7:2], 2'b00};
  wire [3:0] rsel = reg_of(adr);
  wire [3:0] prio_idx = adr[5:2];
  wire wr_f0 = wr_en && (rsel == R_FLAG0);
  wire wr_f1 = wr_en && (rsel == R_FLAG1);

  wire multi = ctrl[`VIP_MULTI_VECTOR_SELECT_BIT];
  wire [2:0] proximity_group_threshold = ctrl[`VIP_TPC_MSB:`VIP_TPC_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Event sources
  wire [NEXT-1:0] ext_pulse;
  vip_edge #(
    .N(NEXT)
  ) u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .line_i(ext_line_i),
    .rise_sel_i(ctrl[`VIP_EDGE_MSB:`VIP_EDGE_LSB]),
    .pulse_o(ext_pulse)
  );

  reg [NSRC-1:0] hw_set;
  always @* begin
    // Persistent sources follow the level, others set on its rising edge
    hw_set = (periph_req_i & `VIP_PERSIST_MASK) | (periph_req_i & ~req_prev & ~`VIP_PERSIST_MASK);
    // External lines come from pins through the edge detectors
    hw_set[`VIP_EXT0_IRQ] = ext_pulse[0];
    hw_set[`VIP_EXT1_IRQ] = ext_pulse[1];
    hw_set[`VIP_EXT2_IRQ] = ext_pulse[2];
    hw_set[`VIP_EXT3_IRQ] = ext_pulse[3];
    hw_set[`VIP_EXT4_IRQ] = ext_pulse[4];
  end

  // Flag of IRQ n at bit n mod 32 of word n/32
  wire [31:0] next_flag0 = wr_f0 ? merge(flag[31:0], wb_dat_i, wb_sel_i) : flag[31:0];
  wire [31:0] next_flag1 = wr_f1 ? merge(flag[63:32], wb_dat_i, wb_sel_i) : flag[63:32];

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration
  // Sixty-four source bits fold onto forty-four vector priority bytes
  wire [NVEC*8-1:0] prio_flat;
  genvar g;
  generate
    for (g = 0; g < `VIP_PRIO_WORDS; g = g + 1) begin : g_pf
      if (g * 4 + 4 <= NVEC) begin : g_full
        assign prio_flat[g*32 +: 32] = prio[g];
      end else begin : g_part
        assign prio_flat[NVEC*8-1:g*32] = prio[g][NVEC*8-1-g*32:0];
      end
    end
  endgenerate

  wire win;
  wire [5:0] win_vec;
  wire [2:0] win_pri;
  vip_arb #(
    .NSRC(NSRC),
    .NVEC(NVEC)
  ) u_arb (
    .flag_i(flag),
    .en_i(en),
    .prio_i(prio_flat),
    .win_o(win),
    .win_irq_o(),
    .win_vec_o(win_vec),
    .win_pri_o(win_pri),
    .win_sub_o()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Proximity timer: low-priority winners wait for the timer to run out
  wire prox_sel = (proximity_group_threshold != 3'h0) && (win_pri <= proximity_group_threshold);
  wire hold = win && prox_sel && !tmr_done && (ptmr != 32'h0);
  wire deliver = win && !hold;

  always @(posedge clk_i) begin
    if (rst_i) begin
      tmr <= 32'h0;
      tmr_run <= 1'b0;
      tmr_done <= 1'b0;
    end else begin
      if (!(win && prox_sel)) begin
        tmr_run <= 1'b0;
        tmr_done <= 1'b0;
      end else if (hold && !tmr_run) begin
        tmr <= ptmr;
        tmr_run <= 1'b1;
      end else if (tmr_run) begin
        if (tmr <= 32'h1) begin
          tmr_run <= 1'b0;
          tmr_done <= 1'b1;
        end
        tmr <= tmr - 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Presentation to the core; only the winner leaves the block
  // No shadow register set is signalled with the request
  wire [5:0] out_vec = multi ? win_vec : 6'h00;
  wire [63:0] vec_off = {58'h0, out_vec} * {32'h0, vspace};

  always @(posedge clk_i) begin
    if (rst_i) begin
      cpu_req_o <= 1'b0;
      cpu_vector_o <= 6'h00;
      cpu_level_o <= 3'h0;
      cpu_vec_addr_o <= 32'h0;
      stat_lvl <= 3'h0;
      stat_vec <= 6'h00;
    end else begin
      cpu_req_o <= deliver;
      if (deliver) begin
        cpu_vector_o <= out_vec;
        cpu_level_o <= win_pri;
        // Entry address from programmable base and spacing
        cpu_vec_addr_o <= vbase + vec_off[31:0];
        // Status keeps the latest presented request
        stat_lvl <= win_pri;
        stat_vec <= win_vec;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  integer k;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `VIP_CTRL_RST;
      ptmr <= `VIP_PTMR_RST;
      vbase <= `VIP_WORD_RST;
      vspace <= `VIP_WORD_RST;
      flag <= {NSRC{1'b0}};
      en <= {NSRC{1'b0}};
      req_prev <= {NSRC{1'b0}};
      for (k = 0; k < `VIP_PRIO_WORDS; k = k + 1) begin
        prio[k] <= `VIP_WORD_RST;
      end
    end else begin
      req_prev <= periph_req_i;
      // Software write takes effect, hardware set wins a same-cycle clear
      flag <= {next_flag1, next_flag0} | hw_set;
      if (wr_en) begin
        case (rsel)
          R_CTRL: begin
            ctrl <= merge(ctrl, wb_dat_i, wb_sel_i) & 32'h0000_171f;
          end
          R_PTMR: begin
            ptmr <= merge(ptmr, wb_dat_i, wb_sel_i);
          end
          R_VBASE: begin
            vbase <= merge(vbase, wb_dat_i, wb_sel_i);
          end
          R_VSPACE: begin
            vspace <= merge(vspace, wb_dat_i, wb_sel_i);
          end
          R_EN0: begin
            en[31:0] <= merge(en[31:0], wb_dat_i, wb_sel_i);
          end
          R_EN1: begin
            en[63:32] <= merge(en[63:32], wb_dat_i, wb_sel_i);
          end
          R_PRIO: begin
            // Only the priority and subpriority bits of each byte are kept
            prio[prio_idx] <= merge(prio[prio_idx], wb_dat_i, wb_sel_i) & 32'h1f1f_1f1f;
          end
          default: begin
            // Status is read-only, flags are merged above, unmapped words are ignored
          end
        endcase
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req && !wb_ack_o) begin
        case (rsel)
          R_CTRL: wb_dat_o <= ctrl;
          R_STAT: wb_dat_o <= {21'h0, stat_lvl, 2'b00, stat_vec};
          R_PTMR: wb_dat_o <= ptmr;
          R_VBASE: wb_dat_o <= vbase;
          R_VSPACE: wb_dat_o <= vspace;
          R_FLAG0: wb_dat_o <= flag[31:0];
          R_FLAG1: wb_dat_o <= flag[63:32];
          R_EN0: wb_dat_o <= en[31:0];
          R_EN1: wb_dat_o <= en[63:32];
          R_PRIO: wb_dat_o <= prio[prio_idx];
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end
endmodule

// ===== test/vip_monitor.sv
`timescale 1ns/100ps
`include "vip_map.vh"
module vip_monitor #(
  parameter NSRC = 64,
  parameter NVEC = 44,
  parameter NEXT = 5
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [NSRC-1:0] periph_req_i,
  input wire [NEXT-1:0] ext_line_i,
  input wire cpu_req_o,
  input wire [5:0] cpu_vector_o,
  input wire [2:0] cpu_level_o,
  input wire [31:0] cpu_vec_addr_o
);
  // Shadow copy of settings; mode copy is delayed so a mode change never races the output
  reg multi_vector_select;
  reg multi_vector_select_d;
  reg [31:0] vbase;
  reg [31:0] vspace;
  wire wr_hit = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i == 4'hf;
  always @(posedge clk_i) begin
    if (rst_i) begin
      multi_vector_select <= 1'b0;
      multi_vector_select_d <= 1'b0;
      vbase <= 32'h0;
      vspace <= 32'h0;
    end else begin
      multi_vector_select_d <= multi_vector_select;
      if (wr_hit && wb_adr_i == `VIP_CTRL_OFS) multi_vector_select <= wb_dat_i[`VIP_MULTI_VECTOR_SELECT_BIT];
      if (wr_hit && wb_adr_i == `VIP_VBASE_OFS) vbase <= wb_dat_i;
      if (wr_hit && wb_adr_i == `VIP_VSPACE_OFS) vspace <= wb_dat_i;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_ack;
    wb_ack_o && !wb_we_i;
  endsequence
  AST_ACK_NEXT:
    assert property (s_req |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ACK_CAUSE:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  AST_DAT_HOLD:
    assert property (s_rd_ack |=> $stable(wb_dat_o)) else $error("read data not held");
  AST_RESET_CLEAR:
    assert property ($fell(rst_i) |-> !cpu_req_o && cpu_vector_o == 6'h00 && cpu_level_o == 3'h0)
    else $error("outputs not clear after reset");
  AST_LEVEL_LIVE:
    assert property (cpu_req_o |-> cpu_level_o != 3'h0) else $error("zero priority presented");
  AST_VEC_RANGE:
    assert property (cpu_req_o |-> cpu_vector_o < NVEC) else $error("vector out of range");
  AST_SINGLE_COMMON:
    assert property (cpu_req_o && !multi_vector_select && !multi_vector_select_d |-> cpu_vector_o == 6'h00) else $error("single mode vector");
  AST_TABLE_ADDR:
    assert property (cpu_req_o |-> cpu_vec_addr_o == vbase + {26'h0, cpu_vector_o} * vspace)
    else $error("vector address wrong");
endmodule
bind vip_top vip_monitor #(.NSRC(NSRC), .NVEC(NVEC), .NEXT(NEXT)) u_vip_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .periph_req_i(periph_req_i), .ext_line_i(ext_line_i), .cpu_req_o(cpu_req_o),
  .cpu_vector_o(cpu_vector_o), .cpu_level_o(cpu_level_o), .cpu_vec_addr_o(cpu_vec_addr_o));

// ===== test/vip_cpu_model.sv
`timescale 1ns/100ps
module vip_cpu_model (
  input wire clk_i,
  input wire rst_i,
  input wire cpu_req_i,
  input wire [5:0] cpu_vector_i,
  output logic [7:0] taken_o,
  output logic [5:0] last_vec_o
);
  logic req_d;
  // Core takes a vector only on a fresh request, as an exception entry would
  always @(posedge clk_i) begin
    if (rst_i) begin
      req_d <= 1'b0;
      taken_o <= 8'h00;
      last_vec_o <= 6'h00;
    end else begin
      req_d <= cpu_req_i;
      if (cpu_req_i && !req_d) begin
        taken_o <= taken_o + 8'h01;
        last_vec_o <= cpu_vector_i;
      end
    end
  end
endmodule

// ===== test/vectored_interrupt_prioritizer_bench.sv
`timescale 1ns/100ps
`include "vip_map.vh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module vectored_interrupt_prioritizer_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [63:0] periph_req_i = 64'h0;
  logic [4:0] ext_line_i = 5'h00;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire cpu_req_o;
  wire [5:0] cpu_vector_o;
  wire [2:0] cpu_level_o;
  wire [31:0] cpu_vec_addr_o;
  wire [7:0] taken;
  wire [5:0] last_vec;
  int fails = 0;
  int cmp_count = 0;
  logic [31:0] q;
  int n;
  always #20 clk_i = ~clk_i;
  vip_top u_vip_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .periph_req_i(periph_req_i), .ext_line_i(ext_line_i),
    .cpu_req_o(cpu_req_o), .cpu_vector_o(cpu_vector_o), .cpu_level_o(cpu_level_o),
    .cpu_vec_addr_o(cpu_vec_addr_o));
  vip_cpu_model u_vip_cpu_model (.clk_i(clk_i), .rst_i(rst_i), .cpu_req_i(cpu_req_o),
    .cpu_vector_i(cpu_vector_o), .taken_o(taken), .last_vec_o(last_vec));
  ////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Entered just after a rising edge; ack and read data are taken at the edge that samples ack high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    k = 0;
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin fails++; report_and_stop; end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
  task automatic rd(input logic [7:0] a); bus(1'b0, a, 32'h0); endtask
  task automatic wait_req(input logic lvl);
    n = 0;
    do begin @(negedge clk_i); n++; end while (cpu_req_o !== lvl && n < 40);
    if (cpu_req_o !== lvl) begin fails++; report_and_stop; end
    @(posedge clk_i);
  endtask
  function automatic logic [7:0] wofs(input logic [7:0] b, input logic [5:0] i);
    return b + {5'h00, i[5], 2'b00};
  endfunction
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(`VIP_CTRL_OFS); `CHK("ctrl reset", `VIP_CTRL_RST, q);
    rd(`VIP_PTMR_OFS); `CHK("ptmr reset", `VIP_PTMR_RST, q);
    wr(8'hfc, 32'hffff_ffff); rd(8'hfc); `CHK("unmapped", 32'h0, q);
    wr(`VIP_STAT_OFS, 32'hffff_ffff); rd(`VIP_STAT_OFS); `CHK("stat ro", 32'h0, q);
    wr(`VIP_CTRL_OFS, 32'hffff_ffff); rd(`VIP_CTRL_OFS); `CHK("ctrl bits", 32'h171f, q);
    wr(`VIP_CTRL_OFS, 32'h0);
  endtask
  task automatic t_single;
    wr(`VIP_PRIO0_OFS, 32'h000c_0c00);
    wr(`VIP_EN0_OFS, 32'h7);
    wr(`VIP_FLAG0_OFS, 32'h7); wait_req(1'b1);
    `CHK("single vec", 6'h00, cpu_vector_o);
    rd(`VIP_STAT_OFS); `CHK("tie winner", 32'h0301, q);
    wr(`VIP_FLAG0_OFS, 32'h5); rd(`VIP_STAT_OFS); `CHK("next winner", 32'h0302, q);
    wr(`VIP_FLAG0_OFS, 32'h1); wait_req(1'b0);
    rd(`VIP_FLAG0_OFS); `CHK("flag kept", 32'h1, q);
    wr(`VIP_FLAG0_OFS, 32'h0);
    wr(`VIP_PRIO0_OFS, 32'h0);
  endtask
  task automatic t_multi;
    logic [5:0] ir [10] = '{0, 1, 2, 6, 28, 32, 35, 40, 60, 63};
    logic [5:0] ve [10] = '{0, 1, 2, 5, 23, 27, 30, 32, 40, 43};
    wr(`VIP_CTRL_OFS, 32'h1000);
    wr(`VIP_VBASE_OFS, 32'h2000);
    wr(`VIP_VSPACE_OFS, 32'h20);
    for (int k = 0; k < 10; k++) begin
      wr(`VIP_PRIO0_OFS + {2'b00, ve[k][5:2], 2'b00}, 32'h14 << {ve[k][1:0], 3'b000});
      wr(wofs(`VIP_EN0_OFS, ir[k]), 32'h1 << ir[k][4:0]);
      wr(wofs(`VIP_FLAG0_OFS, ir[k]), 32'h1 << ir[k][4:0]);
      wait_req(1'b1);
      @(negedge clk_i);
      `CHK("multi vec", ve[k], cpu_vector_o);
      `CHK("taken vec", ve[k], last_vec);
      `CHK("level", 3'h5, cpu_level_o);
      `CHK("address", 32'h2000 + {26'h0, ve[k]} * 32'h20, cpu_vec_addr_o);
      `CHK("taken count", 8'(k + 2), taken);
      @(posedge clk_i);
      wr(wofs(`VIP_FLAG0_OFS, ir[k]), 32'h0);
      wr(wofs(`VIP_EN0_OFS, ir[k]), 32'h0);
      wr(`VIP_PRIO0_OFS + {2'b00, ve[k][5:2], 2'b00}, 32'h0);
      wait_req(1'b0);
    end
  endtask
  task automatic t_persist;
    periph_req_i <= 64'h0000_0008_3000_0000;
    repeat (3) @(posedge clk_i);
    wr(`VIP_FLAG0_OFS, 32'h0);
    wr(`VIP_FLAG1_OFS, 32'h0);
    rd(`VIP_FLAG0_OFS); `CHK("persist", 32'h1000_0000, q & 32'h3000_0000);
    rd(`VIP_FLAG1_OFS); `CHK("usb persist", 32'h8, q);
    periph_req_i <= 64'h0;
    wr(`VIP_FLAG0_OFS, 32'h0);
    wr(`VIP_FLAG1_OFS, 32'h0);
    rd(`VIP_FLAG0_OFS); `CHK("released", 32'h0, q);
  endtask
  task automatic t_ext;
    logic [31:0] c [3] = '{32'h1001, 32'h1001, 32'h101f};
    logic [4:0] l [3] = '{5'h03, 5'h00, 5'h1f};
    logic [31:0] e [3] = '{32'h8, 32'h100, 32'h0084_2108};
    for (int k = 0; k < 3; k++) begin
      wr(`VIP_CTRL_OFS, c[k]);
      ext_line_i <= l[k];
      repeat (6) @(posedge clk_i);
      rd(`VIP_FLAG0_OFS); `CHK("edge flags", e[k], q & 32'h0084_2108);
      wr(`VIP_FLAG0_OFS, 32'h0);
    end
  endtask
  task automatic t_prox;
    logic [31:0] c [3] = '{32'h1200, 32'h1200, 32'h1000};
    logic [31:0] p [3] = '{32'h08, 32'h0c, 32'h08};
    logic s [3] = '{1'b1, 1'b0, 1'b0};
    wr(`VIP_PTMR_OFS, 32'ha);
    wr(`VIP_EN0_OFS, 32'h10);
    for (int k = 0; k < 3; k++) begin
      wr(`VIP_CTRL_OFS, c[k]);
      wr(`VIP_PRIO0_OFS + 8'h04, p[k]);
      wr(`VIP_FLAG0_OFS, 32'h10); wait_req(1'b1);
      `CHK("deferred", s[k], n >= 6);
      wr(`VIP_FLAG0_OFS, 32'h0); wait_req(1'b0);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_single();
    t_multi();
    t_persist();
    t_ext();
    t_prox();
    report_and_stop();
  end
endmodule
